// File: core/adsc_map.vh
// Register map, field positions, reset values and timing counts of the converter control
// Notes on behaviour
// (R1) Channel codes with the upper two bits at 00 select no input; codes 0100 to 1111 select inputs 0 to 11.
// (R2) With the trigger enable bit set an edge of the trigger pin starts a conversion when none runs; with the bit clear it is ignored.
// (R3) The clock select bit picks a 62-cycle period when 0 and a 31-cycle period when 1.
// (R4) The status flag reads 1 while a conversion runs and 0 once it has completed.
// (R5) Writing 1 to the flag starts a conversion, writing 0 stops one, and the flag resets to 0.
// (R6) The 10-bit result is read-only and left aligned over the high and the low result registers.
// (R7) At the end of each period the result registers load the new sample and the flag clears together; a start in that cycle keeps the flag set.
`ifndef ADSC_MAP_VH
`define ADSC_MAP_VH

// ==========================================================================
// Register offsets
`define ADSC_ADDR_RES_HIGH   8'hC4
`define ADSC_ADDR_RES_LOW    8'hC5
`define ADSC_ADDR_MODE       8'hC6
`define ADSC_ADDR_START      8'hC7
`define ADSC_ADDR_IRQ_STAT   8'hC0
`define ADSC_ADDR_IRQ_CLR    8'hC1
`define ADSC_ADDR_IRQ_EN     8'hC2

// ==========================================================================
// Field positions
`define ADSC_MODE_CKS_BIT    7
`define ADSC_MODE_EXT_TRIGGER_ENABLE_BIT   6
`define ADSC_MODE_CH_MSB     3
`define ADSC_START_FLAG_BIT  7
`define ADSC_IRQ_DONE_BIT    0
`define ADSC_IRQ_MISS_BIT    1
`define ADSC_IRQ_STOP_BIT    2
`define ADSC_IRQ_WIDTH       3

// ==========================================================================
// Reset values and fixed read bits
`define ADSC_MODE_RESET      8'h30
`define ADSC_MODE_FIXED      2'h3
`define ADSC_START_FIXED     7'h7F
`define ADSC_RESULT_RESET    10'h000
`define ADSC_IRQ_RESET       3'h0

// ==========================================================================
// Conversion periods in system clock cycles, counter width and first channel code
`define ADSC_PERIOD_SLOW     6'h3E
`define ADSC_PERIOD_FAST     6'h1F
`define ADSC_CNT_WIDTH       6
`define ADSC_CH_FIRST_CODE   4

`endif

// File: core/adsc_conv_timer.v
// Conversion period counter of the converter control
`include "adsc_map.vh"

module adsc_conv_timer
(
  input  wire clk,
  input  wire reset,
  input  wire start,
  input  wire stop,
  input  wire fast,
  output wire busy,
  output wire last
);

  reg  [`ADSC_CNT_WIDTH-1:0] cnt_ff;
  reg  [`ADSC_CNT_WIDTH-1:0] nxt_cnt;

  // ==========================================================================
  // Countdown
  // Start wins over stop so a restart in the stop cycle is never lost
  always @*
  begin
    nxt_cnt = cnt_ff;
    if (start)
    begin
      nxt_cnt = fast ? `ADSC_PERIOD_FAST : `ADSC_PERIOD_SLOW; // [R3]
    end
    else if (stop)
    begin
      nxt_cnt = {`ADSC_CNT_WIDTH{1'b0}};
    end
    else if (cnt_ff != {`ADSC_CNT_WIDTH{1'b0}})
    begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_ff <= {`ADSC_CNT_WIDTH{1'b0}};
    end
    else
    begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy = (cnt_ff != {`ADSC_CNT_WIDTH{1'b0}});
  assign last = (cnt_ff == {{(`ADSC_CNT_WIDTH-1){1'b0}}, 1'b1});

endmodule

// File: core/adsc_top.v
// Top of the converter control: register slave, trigger input, channel decode, result capture
`include "adsc_map.vh"

module adsc_top
(
  input  wire        clk,
  input  wire        reset,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [7:0]  reg_rdata,
  input  wire        ext_trigger_pin,
  input  wire [9:0]  adc_sample,
  output wire [11:0] analog_select,
  output wire        conversion_active_flag,
  output wire        irq
);

  // ==========================================================================
  // Declarations
  reg                      conv_clock_select_ff;
  reg                      ext_trigger_enable_ff;
  reg  [3:0]               channel_ff;
  reg                      active_ff;
  reg                      nxt_active;
  reg  [9:0]               result_ff;
  reg  [`ADSC_IRQ_WIDTH-1:0] irq_stat_ff;
  reg  [`ADSC_IRQ_WIDTH-1:0] nxt_irq_stat;
  reg  [`ADSC_IRQ_WIDTH-1:0] irq_en_ff;
  reg                      irq_ff;
  reg  [7:0]               rdata_ff;
  reg  [7:0]               nxt_rdata;
  reg  [11:0]              select_ff;
  reg                      trig_meta_ff;
  reg                      trig_sync_ff;
  reg                      trig_prev_ff;

  wire                     wr_mode;
  wire                     wr_start;
  wire                     wr_irq_clr;
  wire                     wr_irq_en;
  wire                     sw_start;
  wire                     sw_stop;
  wire                     trig_edge;
  wire                     trig_start;
  wire                     trig_miss;
  wire                     start_req;
  wire                     timer_busy;
  wire                     timer_last;
  wire                     conv_end;
  wire [11:0]              nxt_select;
  wire [`ADSC_IRQ_WIDTH-1:0] nxt_irq_en;

  // ==========================================================================
  // Mode register reset fields
  localparam [7:0]         MODE_RESET = `ADSC_MODE_RESET;

  // ==========================================================================
  // Write decode
  // Writes to read-only or unmapped offsets match no decode and are dropped
  assign wr_mode    = reg_wr && (reg_addr == `ADSC_ADDR_MODE);
  assign wr_start   = reg_wr && (reg_addr == `ADSC_ADDR_START);
  assign wr_irq_clr = reg_wr && (reg_addr == `ADSC_ADDR_IRQ_CLR);
  assign wr_irq_en  = reg_wr && (reg_addr == `ADSC_ADDR_IRQ_EN);

  assign sw_start = wr_start && reg_wdata[`ADSC_START_FLAG_BIT];  // [R5]
  assign sw_stop  = wr_start && !reg_wdata[`ADSC_START_FLAG_BIT]; // [R5]

  // ==========================================================================
  // Mode register
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      conv_clock_select_ff  <= MODE_RESET[`ADSC_MODE_CKS_BIT];
      ext_trigger_enable_ff <= MODE_RESET[`ADSC_MODE_EXT_TRIGGER_ENABLE_BIT];
      channel_ff            <= MODE_RESET[`ADSC_MODE_CH_MSB:0];
    end
    else if (wr_mode)
    begin
      conv_clock_select_ff  <= reg_wdata[`ADSC_MODE_CKS_BIT];
      ext_trigger_enable_ff <= reg_wdata[`ADSC_MODE_EXT_TRIGGER_ENABLE_BIT];
      channel_ff            <= reg_wdata[`ADSC_MODE_CH_MSB:0];
    end
  end

  // ==========================================================================
  // Trigger pin
  // Two flops before any logic; the edge detector looks only at the second
  // Reset level matches the idle low pin so no false edge follows reset
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      trig_meta_ff <= 1'b0;
      trig_sync_ff <= 1'b0;
      trig_prev_ff <= 1'b0;
    end
    else
    begin
      trig_meta_ff <= ext_trigger_pin;
      trig_sync_ff <= trig_meta_ff;
      trig_prev_ff <= trig_sync_ff;
    end
  end

  // Either edge counts; the pin is ignored while the enable is clear
  assign trig_edge  = trig_sync_ff ^ trig_prev_ff;
  assign trig_start = trig_edge && ext_trigger_enable_ff && !active_ff; // [R2]
  assign trig_miss  = trig_edge && ext_trigger_enable_ff && active_ff;

  // A software write of 1 while running restarts the period
  assign start_req = sw_start || trig_start;

  // ==========================================================================
  // Conversion timer
  // The period is fixed at the start edge; a clock select write while busy
  // only affects the next conversion
  adsc_conv_timer u_timer
  (
    .clk   (clk),
    .reset (reset),
    .start (start_req),
    .stop  (sw_stop),
    .fast  (conv_clock_select_ff),
    .busy  (timer_busy),
    .last  (timer_last)
  );

  assign conv_end = timer_busy && timer_last;

  // ==========================================================================
  // Status flag
  // A start in the same cycle as a stop or an end wins
  always @*
  begin
    nxt_active = active_ff;
    if (start_req)
    begin
      nxt_active = 1'b1; // [R5]
    end
    else if (sw_stop || conv_end)
    begin
      nxt_active = 1'b0; // [R4] [R7]
    end
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      active_ff <= 1'b0; // [R5]
    end
    else
    begin
      active_ff <= nxt_active;
    end
  end

  // ==========================================================================
  // Result capture
  // Reset value is only for determinism; software must not rely on it
  // Only the ten result bits are stored; the reserved low bits read as zero
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      result_ff <= `ADSC_RESULT_RESET;
    end
    else if (conv_end)
    begin
      result_ff <= adc_sample; // [R7]
    end
  end

  // ==========================================================================
  // Channel decode
  // One-hot so the front end switches exactly one input or none
  // Codes below the first input code leave every switch open
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi = gi + 1)
    begin : g_sel
      localparam [31:0] CODE_WIDE = gi + `ADSC_CH_FIRST_CODE;
      localparam [3:0]  CODE      = CODE_WIDE[3:0];
      assign nxt_select[gi] = (channel_ff == CODE); // [R1]
    end
  endgenerate

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      select_ff <= 12'h000;
    end
    else
    begin
      select_ff <= nxt_select;
    end
  end

  // ==========================================================================
  // Interrupt status, enable and clear
  // Hardware set wins over a clear in the same cycle
  // The output follows next status and next enable so it never lags either
  assign nxt_irq_en = wr_irq_en ? reg_wdata[`ADSC_IRQ_WIDTH-1:0] : irq_en_ff;

  always @*
  begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_irq_clr)
    begin
      nxt_irq_stat = irq_stat_ff & ~reg_wdata[`ADSC_IRQ_WIDTH-1:0];
    end
    if (conv_end)
    begin
      nxt_irq_stat[`ADSC_IRQ_DONE_BIT] = 1'b1;
    end
    if (trig_miss)
    begin
      nxt_irq_stat[`ADSC_IRQ_MISS_BIT] = 1'b1;
    end
    if (sw_stop && active_ff && !start_req)
    begin
      nxt_irq_stat[`ADSC_IRQ_STOP_BIT] = 1'b1;
    end
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq_stat_ff <= `ADSC_IRQ_RESET;
      irq_en_ff   <= `ADSC_IRQ_RESET;
      irq_ff      <= 1'b0;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      if (wr_irq_en)
      begin
        irq_en_ff <= reg_wdata[`ADSC_IRQ_WIDTH-1:0];
      end
      irq_ff <= |(nxt_irq_stat & nxt_irq_en);
    end
  end

  // ==========================================================================
  // Read path
  // Data stand only in the cycle after the strobe; unmapped reads give zero
  // Registered so the bus output comes straight from a flop
  always @*
  begin
    nxt_rdata = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr == `ADSC_ADDR_RES_HIGH)
      begin
        nxt_rdata = result_ff[9:2]; // [R6]
      end
      else if (reg_addr == `ADSC_ADDR_RES_LOW)
      begin
        nxt_rdata = {result_ff[1:0], 6'h00}; // [R6]
      end
      else if (reg_addr == `ADSC_ADDR_MODE)
      begin
        nxt_rdata = {conv_clock_select_ff, ext_trigger_enable_ff,
                     `ADSC_MODE_FIXED, channel_ff};
      end
      else if (reg_addr == `ADSC_ADDR_START)
      begin
        nxt_rdata = {active_ff, `ADSC_START_FIXED}; // [R4]
      end
      else if (reg_addr == `ADSC_ADDR_IRQ_STAT)
      begin
        nxt_rdata = {5'h00, irq_stat_ff};
      end
      else if (reg_addr == `ADSC_ADDR_IRQ_EN)
      begin
        nxt_rdata = {5'h00, irq_en_ff};
      end
    end
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata              = rdata_ff;
  assign analog_select          = select_ff;
  assign conversion_active_flag = active_ff;
  assign irq                    = irq_ff;

endmodule

// File: verif/adsc_top_asserts.sv
// Port-level checker of the converter control
`include "adsc_map.vh"
module adsc_top_asserts
(
  input wire        clk,
  input wire        reset,
  input wire [7:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        ext_trigger_pin,
  input wire [9:0]  adc_sample,
  input wire [11:0] analog_select,
  input wire        conversion_active_flag,
  input wire        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Shadow of the mode bits; run counter restarts on every start write
  logic       cks_ff;
  logic       trg_ff;
  logic [5:0] cnt_ff;
  wire        act   = conversion_active_flag;
  wire        st_wr = reg_wr && reg_addr == `ADSC_ADDR_START;
  wire        md_wr = reg_wr && reg_addr == `ADSC_ADDR_MODE;
  // The counter shows one less than the period on the last busy cycle
  wire  [5:0] lim   = cks_ff ? `ADSC_PERIOD_FAST - 6'h01 : `ADSC_PERIOD_SLOW - 6'h01;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cks_ff <= 1'b0;
      trg_ff <= 1'b0;
      cnt_ff <= 6'h00;
    end
    else
    begin
      if (md_wr)
      begin
        cks_ff <= reg_wdata[7];
        trg_ff <= reg_wdata[6];
      end
      cnt_ff <= (st_wr || !act) ? 6'h00 : cnt_ff + 6'h01;
    end
  end
  // ==========================================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_start; st_wr && reg_wdata[7] |=> act; endproperty
  a_start: assert property (p_start) else $error("start write ignored");
  property p_stop; st_wr && !reg_wdata[7] |=> !act; endproperty
  a_stop: assert property (p_stop) else $error("stop write ignored");
  property p_end; act && !st_wr && cnt_ff == lim |=> !act; endproperty
  a_end: assert property (p_end) else $error("period too long");
  property p_hold; act && !st_wr && cnt_ff < lim |=> act; endproperty
  a_hold: assert property (p_hold) else $error("period too short");
  property p_rd_flag;
    reg_rd && reg_addr == `ADSC_ADDR_START |=> reg_rdata == {$past(act), 7'h7F};
  endproperty
  a_rd_flag: assert property (p_rd_flag) else $error("start read wrong");
  property p_chan;
    md_wr |=> ##1 analog_select == ($past(reg_wdata[3:2], 2) == 2'b00 ? 12'h000
      : 12'h001 << ($past(reg_wdata[3:0], 2) - 4'h4));
  endproperty
  a_chan: assert property (p_chan) else $error("input select wrong");
  property p_trg_off; !trg_ff && !act && !st_wr |=> !act; endproperty
  a_trg_off: assert property (p_trg_off) else $error("stray start");
  property p_trg_on;
    trg_ff && !act && !st_wr && $changed(ext_trigger_pin) |-> ##[1:6] act;
  endproperty
  a_trg_on: assert property (p_trg_on) else $error("trigger ignored");
endmodule

bind adsc_top adsc_top_asserts u_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_trigger_pin(ext_trigger_pin), .adc_sample(adc_sample),
  .analog_select(analog_select), .conversion_active_flag(conversion_active_flag),
  .irq(irq));

// File: verif/adsc_analog_model.sv
// Analog inputs and trigger pin model of the converter control
module adsc_analog_model
(
  input  wire        clk,
  input  wire [11:0] analog_select,
  input  wire        trig_req,
  output logic [9:0] adc_sample,
  output logic       ext_trigger_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    adc_sample      = 10'h000;
    ext_trigger_pin = 1'b0;
  end
  // With no input selected the line wanders every cycle, so a stale value never matches
  always @(posedge clk)
  begin
    if (trig_req)
      ext_trigger_pin <= ~ext_trigger_pin;
    adc_sample <= ~adc_sample;
    for (int i = 0; i < 12; i++)
      if (analog_select[i])
        adc_sample <= 10'(10'h300 + i * 10'h021);
  end
endmodule

// File: verif/tb_top.sv
// Self-checking bench of the converter control
`include "adsc_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        trig_req = 1'b0;
  wire  [7:0]  reg_rdata;
  wire  [9:0]  adc_sample;
  wire  [11:0] analog_select;
  wire         pin;
  wire         flag;
  wire         irq;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n;
  logic [9:0]  e;
  adsc_top u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_trigger_pin(pin),
    .adc_sample(adc_sample), .analog_select(analog_select),
    .conversion_active_flag(flag), .irq(irq));
  adsc_analog_model u_fe (.clk(clk), .analog_select(analog_select), .trig_req(trig_req),
    .adc_sample(adc_sample), .ext_trigger_pin(pin));
  always #5 clk = ~clk;
  // ==========================================================================
  // Run needs about 390 cycles; the ceiling leaves a wide margin
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fail_count++;
      test_done();
    end
  end
  // ==========================================================================
  // Bus tasks and helpers
  function automatic logic [9:0] smp(input int i);
    return 10'(10'h300 + i * 10'h021);
  endfunction
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 chk({4'h0, reg_rdata}, {4'h0, x});
  endtask
  task automatic trg();
    @(posedge clk);
    trig_req <= 1'b1;
    @(posedge clk);
    trig_req <= 1'b0;
  endtask
  task automatic run(output int k);
    k = 0;
    repeat (200)
    begin
      @(posedge clk);
      #1;
      if (flag !== 1'b1)
        break;
      k++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rdc(`ADSC_ADDR_MODE, 8'h30);
    rdc(`ADSC_ADDR_START, 8'h7F);
    rdc(8'hC3, 8'h00);
    for (int c = 0; c < 16; c++)
    begin
      wr(`ADSC_ADDR_MODE, 8'(c));
      @(posedge clk);
      #1 chk(analog_select, c < 4 ? 12'h000 : 12'h001 << (c - 4));
      rdc(`ADSC_ADDR_MODE, 8'(8'h30 | c));
    end
    $display("test channel done");
    wr(`ADSC_ADDR_MODE, 8'h0F);
    wr(`ADSC_ADDR_IRQ_EN, 8'h01);
    wr(`ADSC_ADDR_START, 8'h80);
    run(n);
    chk(12'(n), 12'h03D);
    e = smp(11);
    rdc(`ADSC_ADDR_RES_HIGH, e[9:2]);
    rdc(`ADSC_ADDR_RES_LOW, {e[1:0], 6'h00});
    chk({11'h000, irq}, 12'h001);
    rdc(`ADSC_ADDR_IRQ_STAT, 8'h01);
    wr(`ADSC_ADDR_IRQ_CLR, 8'h07);
    #1 chk({11'h000, irq}, 12'h000);
    $display("test slow done");
    wr(`ADSC_ADDR_IRQ_EN, 8'h00);
    wr(`ADSC_ADDR_MODE, 8'h84);
    wr(`ADSC_ADDR_START, 8'h80);
    rdc(`ADSC_ADDR_START, 8'hFF);
    run(n);
    chk(12'(n), 12'h01C);
    rdc(`ADSC_ADDR_START, 8'h7F);
    e = smp(0);
    rdc(`ADSC_ADDR_RES_HIGH, e[9:2]);
    chk({11'h000, irq}, 12'h000);
    $display("test fast done");
    wr(`ADSC_ADDR_START, 8'h80);
    repeat (5) @(posedge clk);
    wr(`ADSC_ADDR_START, 8'h00);
    #1 chk({11'h000, flag}, 12'h000);
    wr(`ADSC_ADDR_RES_HIGH, 8'h55);
    rdc(`ADSC_ADDR_RES_HIGH, e[9:2]);
    rdc(`ADSC_ADDR_IRQ_STAT, 8'h05);
    wr(`ADSC_ADDR_IRQ_CLR, 8'h07);
    $display("test stop done");
    wr(`ADSC_ADDR_MODE, 8'h05);
    trg();
    repeat (8) @(posedge clk);
    #1 chk({11'h000, flag}, 12'h000);
    wr(`ADSC_ADDR_MODE, 8'h45);
    for (int k = 0; k < 2; k++)
    begin
      trg();
      repeat (6) @(posedge clk);
      #1 chk({11'h000, flag}, 12'h001);
      if (k == 0)
        trg();
      run(n);
    end
    rdc(`ADSC_ADDR_IRQ_STAT, 8'h03);
    e = smp(1);
    rdc(`ADSC_ADDR_RES_LOW, {e[1:0], 6'h00});
    $display("test trigger done");
    test_done();
  end
endmodule
